/* core/metering_front_end_config_regs.sv */
// metering front end configuration bank behind an avalon-mm slave
//
// Summary of operation
// - the 4-bit peak level sets the comparator threshold at (code+1)*100:1.
// - the 5-bit peak interval in bits 4:0 sets the comparator look time, reset all ones.
// - the interval holds in comparator and lowest modes and resets on entering normal or reduced.
// - each 2-bit gain code gives gain 1, 2, or 4 for both upper codes.
// - gain fields sit at 13:12 down to 1:0 for vc, vb, va, n, ic, ib, ia, reset zero.
// - a one in conversion-off bits 0..6 turns off ia, ib, ic, n, va, vb, vc.
// - bit 0 of the reactive register stops the total reactive calculation, reset zero.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module metering_front_end_config_regs #(
  parameter int CH = 7
)
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic [`BUS_AW-1:0]     address_i,
  input  wire logic                   read_i,
  input  wire logic                   write_i,
  input  wire logic [3:0]             byteenable_i,
  input  wire logic [31:0]            writedata_i,
  output logic      [31:0]            readdata_o,
  output logic                        waitrequest_o,
  input  wire cfg_pkg::power_mode_t   power_mode_i,
  output logic      [3:0]             peak_detect_level_o,
  output logic      [10:0]            peak_ratio_o,
  output logic      [4:0]             peak_detect_interval_o,
  output logic      [`GAIN_BITS-1:0]  gain_sel_o,
  output logic      [CH*`FACT_W-1:0]  gain_factor_o,
  output logic      [`CONV_BITS-1:0]  conv_off_o,
  output logic                        reactive_calc_off_o
);
  import cfg_pkg::*;

  logic [3:0]            peak_detect_level;
  logic [4:0]            peak_detect_interval;
  logic [`GAIN_BITS-1:0] channel_gain_select;
  logic [`CONV_BITS-1:0] adc_channel_disable;
  logic                  reactive_calc_off;
  logic                  ack;
  power_mode_t           prev_mode;
  logic [11:0]           word;
  logic                  wr_go;
  logic                  sel_lp;
  logic                  sel_gain;
  logic                  sel_conv;
  logic                  sel_react;
  logic [15:0]           wmask;
  logic [15:0]           lp_view;
  logic [15:0]           next_lp;
  logic [15:0]           next_gain;
  logic [15:0]           next_rd;
  logic                  enter_normal;
  logic                  enter_meas;

  // merge the enabled byte lanes of the write into the old value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [15:0] m);
    merge16 = (old & ~m) | (wd & m);
  endfunction

  // address decode on the word index; low two address bits are ignored
  assign word      = address_i[`BUS_AW-1:2];
  assign sel_lp    = (word == `IDX_LPCMP);
  assign sel_gain  = (word == `IDX_GAIN);
  assign sel_conv  = (word == `IDX_CONV);
  assign sel_react = (word == `IDX_REACT);
  assign wmask     = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign wr_go     = write_i & ack;

  // gain word after lane merge; the top two bits are dropped on store
  assign next_gain = merge16({2'h0, channel_gain_select}, writedata_i[15:0],
                             wmask);

  // one wait state per access, so every access completes at the second edge
  assign waitrequest_o = (read_i | write_i) & ~ack;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= (read_i | write_i) & ~ack;
  end

  // mode tracking: entry is a change into the mode, not its presence
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_mode <= normal_power_mode;
    else
      prev_mode <= power_mode_i;
  end

  assign enter_normal = (power_mode_i == normal_power_mode) &&
                        (prev_mode != normal_power_mode);
  assign enter_meas   = enter_normal ||
                        ((power_mode_i == reduced_measure_mode) &&
                         (prev_mode != reduced_measure_mode));

  // comparator config word as software sees it
  always_comb
  begin
    lp_view = 16'h0000;
    lp_view[`LVL_HI:`LVL_LO] = peak_detect_level;
    lp_view[`INT_HI:`INT_LO] = peak_detect_interval;
    next_lp = merge16(lp_view, writedata_i[15:0], wmask);
  end

  // level: normal-mode entry beats a same-cycle write, so defaults always land
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      peak_detect_level <= `LVL_RST;
    else if (enter_normal)
      peak_detect_level <= `LVL_RST;
    else if (wr_go && sel_lp)
      peak_detect_level <= next_lp[`LVL_HI:`LVL_LO];
  end

  // interval: kept in comparator and lowest modes, defaulted on measure entry
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      peak_detect_interval <= `INT_RST;
    else if (enter_meas)
      peak_detect_interval <= `INT_RST;
    else if (wr_go && sel_lp)
      peak_detect_interval <= next_lp[`INT_HI:`INT_LO];
  end

  // gain fields, only the used bits are stored
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      channel_gain_select <= `GAIN_RST;
    else if (wr_go && sel_gain)
      channel_gain_select <= next_gain[`GAIN_BITS-1:0];
  end

  // converter disable bits live in the low lane only
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      adc_channel_disable <= `CONV_RST;
    else if (wr_go && sel_conv && byteenable_i[0])
      adc_channel_disable <= writedata_i[`CONV_BITS-1:0];
  end

  // the run-bit ordering is software's job; this bit applies at once
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      reactive_calc_off <= `REACT_RST;
    else if (wr_go && sel_react && byteenable_i[0])
      reactive_calc_off <= writedata_i[`REACT_BIT];
  end

  // read mux; unmapped offsets and reserved bits give zero
  always_comb
  begin
    next_rd = 16'h0000;
    if (sel_lp)
      next_rd = lp_view;
    else if (sel_gain)
      next_rd = {2'h0, channel_gain_select};
    else if (sel_conv)
      next_rd = {9'h000, adc_channel_disable};
    else if (sel_react)
      next_rd = {15'h0000, reactive_calc_off};
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      readdata_o <= 32'h00000000;
    else if (read_i && !ack)
      readdata_o <= {16'h0000, next_rd};
  end

  // data outputs, registered copies of the fields plus the ratio computed from the level
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peak_detect_level_o    <= `LVL_RST;
      peak_ratio_o           <= `RATIO_STEP;
      peak_detect_interval_o <= `INT_RST;
      gain_sel_o             <= `GAIN_RST;
      conv_off_o             <= `CONV_RST;
      reactive_calc_off_o    <= `REACT_RST;
    end
    else
    begin
      peak_detect_level_o    <= peak_detect_level;
      peak_ratio_o           <= ({7'h00, peak_detect_level} + 11'h001)
                                * `RATIO_STEP;
      peak_detect_interval_o <= peak_detect_interval;
      gain_sel_o             <= channel_gain_select;
      conv_off_o             <= adc_channel_disable;
      reactive_calc_off_o    <= reactive_calc_off;
    end
  end

  // per-channel gain decode, channel i at bits 2i+1:2i
  for (genvar i = 0; i < CH; i++)
  begin : g_gain
    gain_decode u_dec
    (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .code_i   (channel_gain_select[i*`GAIN_W +: `GAIN_W]),
      .factor_o (gain_factor_o[i*`FACT_W +: `FACT_W])
    );
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence wr_done(sel);
    wr_go && sel && byteenable_i[1:0] == 2'h3;
  endsequence

  sequence rd_start(sel);
    read_i && !ack && sel;
  endsequence

  ratio_follow_a: assert property (
    ##2 peak_ratio_o == ({7'h00, $past(peak_detect_level)} + 11'h001)
      * `RATIO_STEP)
    else $error("peak ratio wrong for level");
  interval_write_a: assert property (
    wr_done(sel_lp) ##0 !enter_meas |=>
      peak_detect_interval == $past(writedata_i[4:0]))
    else $error("interval write lost");
  interval_entry_a: assert property (
    enter_meas |=> peak_detect_interval == `INT_RST ##1
      peak_detect_interval_o == `INT_RST)
    else $error("interval not defaulted on entry");
  interval_hold_a: assert property (
    (power_mode_i inside {comparator_power_mode, lowest_power_mode})
      && !(wr_go && sel_lp) |=> $stable(peak_detect_interval))
    else $error("interval changed while held");
  gain_write_a: assert property (
    wr_done(sel_gain) |=> gain_sel_o == $past(channel_gain_select)
      ##0 channel_gain_select == $past(writedata_i[13:0]))
    else $error("gain field write wrong");
  conv_write_a: assert property (
    wr_done(sel_conv) |=> ##1 conv_off_o == $past(writedata_i[6:0], 2))
    else $error("conversion off bits wrong");
  react_write_a: assert property (
    wr_done(sel_react) |=> ##1 reactive_calc_off_o ==
      $past(writedata_i[0], 2))
    else $error("reactive disable wrong");
  reserved_zero_a: assert property (
    rd_start(sel_gain) |=> !waitrequest_o && readdata_o[31:14] == 18'h0)
    else $error("reserved bits read nonzero");
  react_reserved_a: assert property (
    rd_start(sel_react) |=> readdata_o[31:1] == 31'h0)
    else $error("reactive reserved bits nonzero");
endmodule
`default_nettype wire

/* common/cfg_consts.svh */
// register indices, field positions, reset values for the config bank
`ifndef METER_CFG_CONSTS_SVH
`define METER_CFG_CONSTS_SVH
`define BUS_AW       14
`define IDX_LPCMP    12'h4b8
`define IDX_GAIN     12'h4b9
`define IDX_CONV     12'h4ba
`define IDX_REACT    12'h4e0
`define LVL_HI       8
`define LVL_LO       5
`define INT_HI       4
`define INT_LO       0
`define LVL_RST      4'h0
`define INT_RST      5'h1f
`define GAIN_W       2
`define GAIN_BITS    14
`define GAIN_RST     14'h0000
`define CONV_BITS    7
`define CONV_RST     7'h00
`define REACT_BIT    0
`define REACT_RST    1'b0
`define RATIO_STEP   11'h064
`define FACT_W       3
`define FACT_X1      3'h1
`define FACT_X2      3'h2
`define FACT_X4      3'h4
`define CODE_X1      2'h0
`define CODE_X2      2'h1
`endif

/* common/cfg_pkg.sv */
// types shared by the metering configuration bank
package cfg_pkg;
  typedef enum logic [1:0]
  {
    normal_power_mode,
    reduced_measure_mode,
    comparator_power_mode,
    lowest_power_mode
  } power_mode_t;
endpackage

/* core/gain_decode.sv */
// one channel: gain select code to registered amplifier gain factor
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module gain_decode
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [`GAIN_W-1:0]   code_i,
  output logic      [`FACT_W-1:0]   factor_o
);
  import cfg_pkg::*;

  // codes two and three both mean four; no code is left unused
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      factor_o <= `FACT_X1;
    else
      case (code_i)
        `CODE_X1: factor_o <= `FACT_X1;
        `CODE_X2: factor_o <= `FACT_X2;
        default:  factor_o <= `FACT_X4;
      endcase
  end

  // factor follows the code one cycle later
  gain_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 factor_o == (($past(code_i) == `CODE_X1) ? `FACT_X1 :
      ($past(code_i) == `CODE_X2) ? `FACT_X2 : `FACT_X4))
    else $error("gain factor does not match code");
endmodule
`default_nettype wire

/* test/host_master.sv */
// bus master model standing in for host software on the register port
`timescale 1ns/1ps
`default_nettype none
module host_master
(
  input  wire logic        mclk_i,
  output logic      [13:0] address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [3:0]  byteenable_o,
  output logic      [31:0] writedata_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  // bus idle at time zero
  initial
  begin
    address_o = 14'h0000;
    read_o = 1'b0;
    write_o = 1'b0;
    byteenable_o = 4'hf;
    writedata_o = 32'h0000_0000;
  end
  // one access; request held until waitrequest is seen low at a rising edge
  task automatic access(input logic wr, input logic [13:0] a,
                        input logic [15:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    address_o <= a;
    writedata_o <= {16'h0000, d};
    write_o <= wr;
    read_o <= ~wr;
    // an unknown waitrequest keeps waiting, so the watchdog catches it
    do
      @(posedge mclk_i);
    while (waitrequest_i !== 1'b0);
    // read data and write completion both belong to this edge
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/metering_front_end_config_regs_test.sv */
// self-checking bench for the metering configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module test_metering_front_end_config_regs;
  import cfg_pkg::*;
  localparam logic [13:0] A_LP = {`IDX_LPCMP, 2'b00};
  localparam logic [13:0] A_GN = {`IDX_GAIN, 2'b00};
  localparam logic [13:0] A_CV = {`IDX_CONV, 2'b00};
  localparam logic [13:0] A_RV = {`IDX_REACT, 2'b00};
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  power_mode_t mode = normal_power_mode;
  wire  [13:0] addr;
  wire         rd_s, wr_s, wreq;
  wire  [3:0]  be;
  wire  [31:0] wdat, rdat;
  wire  [3:0]  lvl;
  wire  [10:0] ratio;
  wire  [4:0]  intv;
  wire  [13:0] gsel;
  wire  [20:0] gfac;
  wire  [6:0]  conv;
  wire         react;
  int          n_errors = 0;
  int          n_checks = 0;

  // free-running 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  host_master host_u (.mclk_i(mclk_i), .address_o(addr), .read_o(rd_s),
    .write_o(wr_s), .byteenable_o(be), .writedata_o(wdat),
    .readdata_i(rdat), .waitrequest_i(wreq));

  metering_front_end_config_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .address_i(addr), .read_i(rd_s), .write_i(wr_s), .byteenable_i(be),
    .writedata_i(wdat), .readdata_o(rdat), .waitrequest_o(wreq),
    .power_mode_i(mode), .peak_detect_level_o(lvl), .peak_ratio_o(ratio),
    .peak_detect_interval_o(intv), .gain_sel_o(gsel),
    .gain_factor_o(gfac), .conv_off_o(conv), .reactive_calc_off_o(react));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    logic [31:0] u;
    host_u.access(1'b1, a, d, u);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] g;
    host_u.access(1'b0, a, 16'h0000, g);
    chk(g, e);
  endtask
  // outputs trail the write edge by one cycle
  task automatic settle;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic set_mode(input power_mode_t m);
    @(posedge mclk_i);
    mode <= m;
    settle;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, far beyond the roughly 130 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(A_LP, 32'h0000_001f);
    rd(A_GN, 32'h0000_0000);
    rd(A_CV, 32'h0000_0000);
    rd(A_RV, 32'h0000_0000);
    chk(32'(ratio), 32'h0000_0064);
    chk(32'(gfac), 32'h0004_9249);
    // reactive bit first, as host software must do before running
    wr(A_RV, 16'hffff);
    rd(A_RV, 32'h0000_0001);
    settle;
    chk(32'(react), 32'h0000_0001);
    wr(A_GN, 16'hf939);
    rd(A_GN, 32'h0000_3939);
    settle;
    chk(32'(gsel), 32'h0000_3939);
    chk(32'(gfac), {11'h000, 21'o4421442});
    for (int i = 0; i < 7; i++)
    begin
      wr(A_CV, 16'(1 << i));
      settle;
      chk(32'(conv), 32'(1 << i));
    end
    wr(A_CV, 16'hffff);
    rd(A_CV, 32'h0000_007f);
    wr(14'h0004, 16'hffff);
    rd(14'h0004, 32'h0000_0000);
    wr(A_LP, 16'hffea);
    rd(A_LP, 32'h0000_01ea);
    settle;
    chk(32'(ratio), 32'h0000_0640);
    chk(32'(intv), 32'h0000_000a);
    set_mode(comparator_power_mode);
    chk(32'(intv), 32'h0000_000a);
    set_mode(lowest_power_mode);
    chk(32'(intv), 32'h0000_000a);
    set_mode(reduced_measure_mode);
    chk(32'(intv), 32'h0000_001f);
    chk(32'(lvl), 32'h0000_000f);
    set_mode(comparator_power_mode);
    wr(A_LP, 16'h01ea);
    rd(A_LP, 32'h0000_01ea);
    set_mode(normal_power_mode);
    chk(32'(intv), 32'h0000_001f);
    chk(32'(ratio), 32'h0000_0064);
    report_and_stop;
  end
endmodule
`default_nettype wire
